//--- logic/sync_mon_pkg.sv
// constants and carrier types for the dual-channel input synchronisation monitor
// assumes a single system clock of CLK_MHZ and six sensor pairs in three supply groups
package sync_mon_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SYNC_A_LEAD_MS  = 2000;
  localparam int unsigned SYNC_B_LEAD_MS  = 4000;
  localparam int unsigned SYNC_A_LEAD_CYC = SYNC_A_LEAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SYNC_B_LEAD_CYC = SYNC_B_LEAD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SYNC_CNT_W      = 30;

  // test pulses on the supply terminals, used for short detection
  localparam int unsigned TEST_IDLE_US    = 10000;
  localparam int unsigned TEST_LOW_US     = 500;
  localparam int unsigned TEST_IDLE_CYC   = TEST_IDLE_US * CLK_MHZ;
  localparam int unsigned TEST_LOW_CYC    = TEST_LOW_US * CLK_MHZ;
  localparam int unsigned TEST_CNT_W      = 22;

  //////////////////////////////////////////////////////////////////////////////
  // topology
  localparam int unsigned NUM_PAIRS       = 6;
  localparam int unsigned NUM_GROUPS      = 3;
  localparam int unsigned SYNC_STAGES     = 2;

  // wiring mode strap
  localparam logic        MODE_CROSS      = 1'b0;
  localparam logic        MODE_COMMON     = 1'b1;

  // reset values
  localparam logic        SUPPLY_ON       = 1'b1;
  localparam logic        CHAN_IDLE       = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic a;
    logic b;
  } chan_pair_t;

  typedef struct packed {
    logic active;
    logic sync_fault;
    logic ilk_fault;
  } pair_status_t;

endpackage : sync_mon_pkg

//--- logic/pair_sync_checker.sv
// asymmetric activation window check for one channel pair
// assumes chan_i is already synchronised to mclk_i; hold_i freezes the check
`timescale 1ns/1ps
module pair_sync_checker
  import sync_mon_pkg::*;
#(
  parameter int unsigned A_LEAD_CYC = SYNC_A_LEAD_CYC,
  parameter int unsigned B_LEAD_CYC = SYNC_B_LEAD_CYC,
  parameter int unsigned CNT_W      = SYNC_CNT_W
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // channel levels
  input  wire chan_pair_t chan_i,
  input  wire logic       hold_i,
  // result
  output logic            active_o,
  output logic            fault_o
);

  generate
    if (A_LEAD_CYC < 1 || B_LEAD_CYC < 1 || B_LEAD_CYC >= (64'd1 << CNT_W) || A_LEAD_CYC >= (64'd1 << CNT_W)) begin : g_chk
      $error("pair_sync_checker: window does not fit counter");
    end
  endgenerate

  typedef enum {ST_IDLE, ST_WAIT_B, ST_WAIT_A, ST_BOTH, ST_RELEASE, ST_FAIL} sync_state_t;

  sync_state_t      state;
  sync_state_t      next_state;
  logic [CNT_W-1:0] cnt;
  logic             timeout;

  localparam logic [CNT_W-1:0] A_LIMIT = CNT_W'(A_LEAD_CYC - 1);
  localparam logic [CNT_W-1:0] B_LIMIT = CNT_W'(B_LEAD_CYC - 1);

  always_comb begin
    timeout = ((state == ST_WAIT_B) && (cnt == A_LIMIT)) || ((state == ST_WAIT_A) && (cnt == B_LIMIT));
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (chan_i.a && chan_i.b)
          next_state = ST_BOTH;
        else if (chan_i.a)
          next_state = ST_WAIT_B;
        else if (chan_i.b)
          next_state = ST_WAIT_A;
      end
      ST_WAIT_B: begin
        if (chan_i.a && chan_i.b)
          next_state = ST_BOTH;
        else if (timeout)
          next_state = ST_FAIL;
        else if (!chan_i.a)
          next_state = chan_i.b ? ST_WAIT_A : ST_IDLE;
      end
      ST_WAIT_A: begin
        if (chan_i.a && chan_i.b)
          next_state = ST_BOTH;
        else if (timeout)
          next_state = ST_FAIL;
        else if (!chan_i.b)
          next_state = chan_i.a ? ST_WAIT_B : ST_IDLE;
      end
      ST_BOTH: begin
        if (!chan_i.a || !chan_i.b)
          next_state = ST_RELEASE;
      end
      // a new activation is only judged after both channels have opened
      ST_RELEASE: begin
        if (!chan_i.a && !chan_i.b)
          next_state = ST_IDLE;
      end
      ST_FAIL: begin
        next_state = ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      state <= ST_IDLE;
    else if (!hold_i)
      state <= next_state;
  end

  // window timer restarts on every change of state
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      cnt <= '0;
    else if (!hold_i && next_state != state)
      cnt <= '0;
    else if (!hold_i && (state == ST_WAIT_A || state == ST_WAIT_B))
      cnt <= cnt + CNT_W'(1);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_o <= 1'b0;
      fault_o  <= 1'b0;
    end else begin
      active_o <= (next_state == ST_BOTH) && !hold_i;
      fault_o  <= !hold_i && timeout;
    end
  end

endmodule : pair_sync_checker

//--- logic/dual_channel_input_sync_monitor.sv
// six dual-channel safety input monitor: activation window, short detection, error latch
// assumes channel pins are asynchronous levels, active high, supplies driven by supply_*_o
`timescale 1ns/1ps
module dual_channel_input_sync_monitor
  import sync_mon_pkg::*;
#(
  parameter int unsigned A_LEAD_CYC = SYNC_A_LEAD_CYC,
  parameter int unsigned B_LEAD_CYC = SYNC_B_LEAD_CYC,
  parameter int unsigned IDLE_CYC   = TEST_IDLE_CYC,
  parameter int unsigned LOW_CYC    = TEST_LOW_CYC
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  // sensor channel terminals, sensors A to F
  input  wire logic                  pair1_chan_a_i,
  input  wire logic                  pair1_chan_b_i,
  input  wire logic                  pair2_chan_a_i,
  input  wire logic                  pair2_chan_b_i,
  input  wire logic                  pair3_chan_a_i,
  input  wire logic                  pair3_chan_b_i,
  input  wire logic                  pair4_chan_a_i,
  input  wire logic                  pair4_chan_b_i,
  input  wire logic                  pair5_chan_a_i,
  input  wire logic                  pair5_chan_b_i,
  input  wire logic                  pair6_chan_a_i,
  input  wire logic                  pair6_chan_b_i,
  // wiring mode strap
  input  wire logic                  common_mode_i,
  // supply terminals, one of each per group
  output logic [NUM_GROUPS-1:0]      supply_a_o,
  output logic [NUM_GROUPS-1:0]      supply_b_o,
  // status
  output pair_status_t [NUM_PAIRS-1:0] pair_status_o,
  output logic                       fault_o,
  output logic                       safety_ok_o
);

  generate
    if (LOW_CYC < 1 || IDLE_CYC < 1 || IDLE_CYC >= (64'd1 << TEST_CNT_W) || LOW_CYC >= (64'd1 << TEST_CNT_W)) begin : g_chk
      $error("dual_channel_input_sync_monitor: test timing does not fit counter");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  localparam int unsigned RAW_W = 2 * NUM_PAIRS + 1;

  logic [RAW_W-1:0]            raw_pins;
  logic [RAW_W-1:0]            sync_q1;
  logic [RAW_W-1:0]            sync_q2;
  chan_pair_t [NUM_PAIRS-1:0]  chan_now;
  logic                        mode_common;

  // pair order A..F, channel a above channel b in each pair
  assign raw_pins = {common_mode_i,
                     pair6_chan_a_i, pair6_chan_b_i, pair5_chan_a_i, pair5_chan_b_i,
                     pair4_chan_a_i, pair4_chan_b_i, pair3_chan_a_i, pair3_chan_b_i,
                     pair2_chan_a_i, pair2_chan_b_i, pair1_chan_a_i, pair1_chan_b_i};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q1 <= '0;
      sync_q2 <= '0;
    end else begin
      sync_q1 <= raw_pins;
      sync_q2 <= sync_q1;
    end
  end

  assign chan_now    = sync_q2[2*NUM_PAIRS-1:0];
  assign mode_common = sync_q2[RAW_W-1];

  //////////////////////////////////////////////////////////////////////////////
  // supply test pulses

  typedef enum {TP_IDLE, TP_LOW_A, TP_LOW_B, TP_RECOVER} test_state_t;

  test_state_t           tp_state;
  test_state_t           next_tp_state;
  logic [TEST_CNT_W-1:0] tp_cnt;
  logic                  tp_last;

  localparam logic [TEST_CNT_W-1:0] IDLE_LOAD = TEST_CNT_W'(IDLE_CYC - 1);
  localparam logic [TEST_CNT_W-1:0] LOW_LOAD  = TEST_CNT_W'(LOW_CYC - 1);

  assign tp_last = (tp_cnt == '0);

  always_comb begin
    next_tp_state = tp_state;
    if (tp_last) begin
      unique case (tp_state)
        TP_IDLE:    next_tp_state = TP_LOW_A;
        TP_LOW_A:   next_tp_state = TP_LOW_B;
        TP_LOW_B:   next_tp_state = TP_RECOVER;
        TP_RECOVER: next_tp_state = TP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tp_state <= TP_IDLE;
      tp_cnt   <= IDLE_LOAD;
    end else begin
      tp_state <= next_tp_state;
      if (!tp_last)
        tp_cnt <= tp_cnt - TEST_CNT_W'(1);
      else if (next_tp_state == TP_IDLE)
        tp_cnt <= IDLE_LOAD;
      else
        tp_cnt <= LOW_LOAD;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      supply_a_o <= {NUM_GROUPS{SUPPLY_ON}};
      supply_b_o <= {NUM_GROUPS{SUPPLY_ON}};
    end else begin
      supply_a_o <= {NUM_GROUPS{next_tp_state != TP_LOW_A}};
      supply_b_o <= {NUM_GROUPS{next_tp_state != TP_LOW_B}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel levels seen by the window check, frozen while a pulse is out and through the recovery phase after it

  chan_pair_t [NUM_PAIRS-1:0] chan_held;
  logic                       masked;

  assign masked = (tp_state != TP_IDLE);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      chan_held <= {NUM_PAIRS{CHAN_IDLE, CHAN_IDLE}};
    else if (!masked)
      chan_held <= chan_now;
  end

  //////////////////////////////////////////////////////////////////////////////
  // activation window per pair

  logic [NUM_PAIRS-1:0] pair_active;
  logic [NUM_PAIRS-1:0] sync_fault_ev;

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    pair_sync_checker #(
      .A_LEAD_CYC (A_LEAD_CYC),
      .B_LEAD_CYC (B_LEAD_CYC),
      .CNT_W      (SYNC_CNT_W)
    ) u_sync (
      .mclk_i   (mclk_i),
      .rst_b_i  (rst_b_i),
      .chan_i   (chan_held[p]),
      .hold_i   (masked),
      .active_o (pair_active[p]),
      .fault_o  (sync_fault_ev[p])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // short detection between the two channels of a pair

  // with one supply pulled low, its own channel must follow it low and the other channel must stay high
  function automatic logic pulse_mismatch(input chan_pair_t now, input logic pulse_on_a);
    if (pulse_on_a)
      return now.a | ~now.b;
    else
      return ~now.a | now.b;
  endfunction : pulse_mismatch

  logic [NUM_PAIRS-1:0] ilk_fault_ev;

  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      ilk_fault_ev[p] = 1'b0;
      if (mode_common != MODE_COMMON && tp_last && chan_held[p].a && chan_held[p].b) begin
        if (tp_state == TP_LOW_A)
          ilk_fault_ev[p] = pulse_mismatch(chan_now[p], 1'b1);
        else if (tp_state == TP_LOW_B)
          ilk_fault_ev[p] = pulse_mismatch(chan_now[p], 1'b0);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault latches, cleared only by reset, and outputs

  logic [NUM_PAIRS-1:0] sync_err;
  logic [NUM_PAIRS-1:0] ilk_err;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_err <= '0;
      ilk_err  <= '0;
    end else begin
      sync_err <= sync_err | sync_fault_ev;
      ilk_err  <= ilk_err | ilk_fault_ev;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pair_status_o <= '0;
      fault_o       <= 1'b0;
      safety_ok_o   <= 1'b0;
    end else begin
      for (int p = 0; p < NUM_PAIRS; p++)
        pair_status_o[p] <= '{active: pair_active[p], sync_fault: sync_err[p], ilk_fault: ilk_err[p]};
      fault_o     <= |{sync_err, ilk_err};
      // unused inputs are bridged, so all six pairs must be active
      safety_ok_o <= (&pair_active) && !(|{sync_err, ilk_err, sync_fault_ev, ilk_fault_ev});
    end
  end

endmodule : dual_channel_input_sync_monitor

//--- bench/sync_mon_properties.sv
// port checker for the dual-channel input monitor
// assumes binding into dual_channel_input_sync_monitor, one clock domain
`timescale 1ns/1ps
module sync_mon_properties
  import sync_mon_pkg::*;
#(
  parameter int unsigned LOW_CYC = TEST_LOW_CYC
) (
  // clock and reset
  input wire logic                         mclk_i,
  input wire logic                         rst_b_i,
  // monitor outputs and strap
  input wire logic                         common_mode_i,
  input wire logic [NUM_GROUPS-1:0]        supply_a_o,
  input wire logic [NUM_GROUPS-1:0]        supply_b_o,
  input wire pair_status_t [NUM_PAIRS-1:0] pair_status_o,
  input wire logic                         fault_o,
  input wire logic                         safety_ok_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [NUM_PAIRS-1:0] act;
  logic [NUM_PAIRS-1:0] flt;
  logic [NUM_PAIRS-1:0] ilk;
  logic [31:0]          low_n;
  always_comb begin
    for (int i = 0; i < NUM_PAIRS; i++) begin
      act[i] = pair_status_o[i].active;
      flt[i] = pair_status_o[i].sync_fault | pair_status_o[i].ilk_fault;
      ilk[i] = pair_status_o[i].ilk_fault;
    end
  end
  // length of the current low phase of supply a
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_n <= 32'h0;
    end else begin
      low_n <= supply_a_o[0] ? 32'h0 : low_n + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_FAULT_OR: assert property ($rose(|flt) |-> ##[0:1] fault_o)
    else $error("pair fault not reflected on fault output");
  AST_FAULT_STICKY: assert property (fault_o |=> fault_o)
    else $error("fault output cleared without reset");
  AST_SAFE_FAULT: assert property (fault_o |-> ##1 !safety_ok_o)
    else $error("safety output on with fault latched");
  AST_SAFE_ACTIVE: assert property (safety_ok_o |-> (&act || $past(&act)))
    else $error("safety output on while a pair is inactive");
  AST_ILK_COMMON: assert property ($rose(|ilk) |-> !common_mode_i && $past(!common_mode_i, 4))
    else $error("short fault raised in common wiring");
  AST_GROUPS: assert property (supply_a_o inside {3'h0, 3'h7} && supply_b_o inside {3'h0, 3'h7})
    else $error("supply groups differ");
  AST_PULSE_EXCL: assert property (!(supply_a_o[0] == 1'b0 && supply_b_o[0] == 1'b0))
    else $error("both supplies low together");
  AST_PULSE_ORDER: assert property ($rose(supply_a_o[0]) |-> !supply_b_o[0])
    else $error("pulse b does not follow pulse a");
  AST_PULSE_LEN: assert property ($rose(supply_a_o[0]) |-> low_n == LOW_CYC)
    else $error("pulse a length wrong");
  // status trails the start of the pulse by two registers
  AST_PULSE_INACT: assert property (!supply_a_o[0] && $past(!supply_a_o[0]) && $past(!supply_a_o[0], 2) |-> act == 6'h0)
    else $error("pair active during test pulse");
  COV_SAFE: cover property ($rose(safety_ok_o));
  COV_SYNC: cover property ($rose(|flt) && !(|ilk));
  COV_ILK: cover property ($rose(|ilk));
endmodule : sync_mon_properties

bind dual_channel_input_sync_monitor sync_mon_properties #(.LOW_CYC(LOW_CYC)) i_sync_mon_properties (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .common_mode_i(common_mode_i), .supply_a_o(supply_a_o),
  .supply_b_o(supply_b_o), .pair_status_o(pair_status_o), .fault_o(fault_o), .safety_ok_o(safety_ok_o));

//--- bench/sensor_model.sv
// model of six two-contact switches fed from the monitor supplies
// assumes open contacts read low through a pull-down
`timescale 1ns/1ps
module sensor_model
  import sync_mon_pkg::*;
(
  // supplies from the monitor
  input  wire logic [NUM_GROUPS-1:0] supply_a_i,
  input  wire logic [NUM_GROUPS-1:0] supply_b_i,
  // contact states and injected shorts
  input  wire logic [NUM_PAIRS-1:0]  closed_a_i,
  input  wire logic [NUM_PAIRS-1:0]  closed_b_i,
  input  wire logic [NUM_PAIRS-1:0]  short_i,
  // channel terminals
  output logic      [NUM_PAIRS-1:0]  chan_a_o,
  output logic      [NUM_PAIRS-1:0]  chan_b_o
);
  logic [NUM_PAIRS-1:0] ra;
  logic [NUM_PAIRS-1:0] rb;
  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      ra[p] = closed_a_i[p] & supply_a_i[p/2];
      rb[p] = closed_b_i[p] & supply_b_i[p/2];
      // a short ties both terminals together
      chan_a_o[p] = short_i[p] ? (ra[p] | rb[p]) : ra[p];
      chan_b_o[p] = short_i[p] ? (ra[p] | rb[p]) : rb[p];
    end
  end
endmodule : sensor_model

//--- bench/test_dual_channel_input_sync_monitor.sv
// self-checking bench for the dual-channel input monitor
// assumes shortened windows: a lead 20, b lead 40, idle 50, pulse 8 cycles
`timescale 1ns/1ps
module test_dual_channel_input_sync_monitor;
  import sync_mon_pkg::*;
  localparam int unsigned LOW = 8;
  logic                         mclk_i  = 1'b0;
  logic                         rst_b_i = 1'b0;
  logic                         cm      = MODE_CROSS;
  logic [5:0]                   ca      = 6'h00;
  logic [5:0]                   cb      = 6'h00;
  logic [5:0]                   sh      = 6'h00;
  logic [5:0]                   pa;
  logic [5:0]                   pb;
  logic [2:0]                   sa;
  logic [2:0]                   sb;
  pair_status_t [NUM_PAIRS-1:0] st;
  logic                         flt;
  logic                         ok;
  int                           n_errors = 0;
  int                           total_checks = 0;
  initial forever #2 mclk_i = ~mclk_i;
  dual_channel_input_sync_monitor #(.A_LEAD_CYC(20), .B_LEAD_CYC(40), .IDLE_CYC(50), .LOW_CYC(LOW))
    i_dual_channel_input_sync_monitor (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .pair1_chan_a_i(pa[0]), .pair1_chan_b_i(pb[0]), .pair2_chan_a_i(pa[1]), .pair2_chan_b_i(pb[1]),
    .pair3_chan_a_i(pa[2]), .pair3_chan_b_i(pb[2]), .pair4_chan_a_i(pa[3]), .pair4_chan_b_i(pb[3]),
    .pair5_chan_a_i(pa[4]), .pair5_chan_b_i(pb[4]), .pair6_chan_a_i(pa[5]), .pair6_chan_b_i(pb[5]),
    .common_mode_i(cm), .supply_a_o(sa), .supply_b_o(sb), .pair_status_o(st), .fault_o(flt),
    .safety_ok_o(ok));
  sensor_model i_sensor_model (.supply_a_i(sa), .supply_b_i(sb), .closed_a_i(ca), .closed_b_i(cb),
    .short_i(sh), .chan_a_o(pa), .chan_b_o(pb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // bounded wait on supply b (which 0) or the safety output (which 1)
  task automatic wait_for(input int which, input logic lvl);
    int k;
    k = 0;
    while (((which == 0) ? sb[0] : ok) !== lvl) begin
      @(posedge mclk_i);
      k++;
      if (k > 400) begin
        n_errors++;
        $display("ERROR at %0t: wait timed out", $time);
        wrap_up();
      end
    end
  endtask : wait_for
  task automatic do_reset(input logic cm_v);
    rst_b_i <= 1'b0;
    cm <= cm_v;
    ca <= 6'h00;
    cb <= 6'h00;
    sh <= 6'h00;
    repeat (10) @(posedge mclk_i);
    check(18'({sa, sb}), 18'h0003F);
    check(st, 18'h00000);
    check(18'({flt, ok}), 18'h00000);
    rst_b_i <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  // all sensors close together; unused inputs count as bridged
  task automatic t_all();
    do_reset(MODE_CROSS);
    ca <= 6'h3F;
    cb <= 6'h3F;
    wait_for(1, 1'b1);
    check(18'(flt), 18'h00000);
  endtask : t_all
  // one pair leads with a or b, partner follows after gap cycles of idle
  task automatic t_lead(input int p, input bit a_first, input int gap, input bit expf);
    do_reset(MODE_CROSS);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    repeat (LOW + 2) @(posedge mclk_i);
    if (a_first) begin
      ca[p] <= 1'b1;
    end else begin
      cb[p] <= 1'b1;
    end
    repeat (gap) @(posedge mclk_i);
    ca[p] <= 1'b1;
    cb[p] <= 1'b1;
    repeat (10) @(posedge mclk_i);
    for (int q = 0; q < NUM_PAIRS; q++) begin
      check(18'(st[q].sync_fault), 18'(q == p && expf));
    end
    check(18'(st[p].active), 18'(!expf));
    check(18'({flt, ok}), 18'({expf, 1'b0}));
  endtask : t_lead
  // short on pair 3 across a full pulse period
  task automatic t_short(input logic cm_v);
    do_reset(cm_v);
    ca <= 6'h3F;
    cb <= 6'h3F;
    sh[2] <= 1'b1;
    // look in the idle phase of the third pulse period, clear of any pulse
    repeat (180) @(posedge mclk_i);
    for (int q = 0; q < NUM_PAIRS; q++) begin
      check(18'(st[q].ilk_fault), 18'(q == 2 && cm_v == MODE_CROSS));
    end
    check(18'({flt, ok}), 18'({cm_v == MODE_CROSS, cm_v == MODE_COMMON}));
  endtask : t_short
  initial begin
    @(posedge mclk_i);
    t_all();
    t_lead(0, 1'b1, 10, 1'b0);
    t_lead(1, 1'b1, 30, 1'b1);
    t_lead(4, 1'b0, 30, 1'b0);
    t_lead(5, 1'b0, 45, 1'b1);
    t_short(MODE_CROSS);
    t_short(MODE_COMMON);
    wrap_up();
  end
endmodule : test_dual_channel_input_sync_monitor
